/* File: verilog/uht_pkg.sv */
// constants, field layouts and types of the half-duplex serial core
// assumes one 50 MHz system clock and a byte-addressed register port
package uht_pkg;

    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int DIV_W = 16;
    localparam int FRAC_W = 4;
    localparam int WORD_W = 9;
    localparam int FRAME_W = 11;

    localparam logic [7:0] OFS_CTRL1 = 8'h00;
    localparam logic [7:0] OFS_CTRL2 = 8'h04;
    localparam logic [7:0] OFS_BAUD = 8'h08;
    localparam logic [7:0] OFS_STS = 8'h0C;
    localparam logic [7:0] OFS_DATA = 8'h10;

    localparam int CTRL1_W = 13;
    localparam int CTRL2_W = 4;
    localparam int STS_TXE = 0;
    localparam int STS_TC = 1;
    localparam int STS_RXNE = 2;
    localparam int STS_IDLE = 3;
    localparam int STS_OVR = 4;
    localparam int STS_NOISE = 5;
    localparam int STS_FE = 6;
    localparam int STS_W = 7;

    localparam logic [5:0] OS_FULL = 6'h10;
    localparam logic [5:0] OS_HALF = 6'h08;
    localparam logic [1:0] STOP_1 = 2'h0;
    localparam logic [1:0] STOP_HALF = 2'h1;
    localparam logic [1:0] STOP_2 = 2'h2;
    localparam logic [1:0] STOP_ONEHALF = 2'h3;
    localparam logic [2:0] HALVES_1 = 3'h2;
    localparam logic [2:0] HALVES_HALF = 3'h1;
    localparam logic [2:0] HALVES_2 = 3'h4;
    localparam logic [2:0] HALVES_ONEHALF = 3'h3;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_9 = 4'h9;
    localparam logic [3:0] IDLE_EXTRA = 4'h2;

    // CTRL1 layout, bit 0 is peripheral_enable
    typedef struct packed {
        logic error_irq_enable;
        logic idle_irq_enable;
        logic rx_not_empty_irq_enable;
        logic tx_complete_irq_enable;
        logic tx_empty_irq_enable;
        logic break_request;
        logic oversampling_select;
        logic parity_select;
        logic parity_enable;
        logic word_length_select;
        logic receive_enable;
        logic transmit_enable;
        logic peripheral_enable;
    } uht_ctrl1_s;

    typedef struct packed {
        logic dma_enable;
        logic half_duplex_enable;
        logic [1:0] stop_bits_select;
    } uht_ctrl2_s;

    typedef enum logic [1:0] {TX_IDLE, TX_BITS, TX_STOP} uht_tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_BITS, RX_STOP} uht_rx_e;

endpackage : uht_pkg

/* File: verilog/uht_sync.sv */
// two-stage synchroniser for pin levels
// assumes inputs are asynchronous to clk_sys
`timescale 1ns/10ps
`default_nettype none
module uht_sync #(
    parameter int W = 2
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= '1;
            dout <= '1;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule : uht_sync
`default_nettype wire

/* File: verilog/uht_baud.sv */
// fractional divider giving the oversampling tick
// assumes divider is 12.4 fixed point; one bit equals divider clocks at 16x, half that at 8x
`timescale 1ns/10ps
`default_nettype none
module uht_baud #(
    parameter int DIV_W = 16,
    parameter int FRAC_W = 4
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic enable,
    input wire logic [DIV_W-1:0] divider,
    output logic tick
);
    localparam logic [DIV_W:0] STEP = (DIV_W+1)'(1 << FRAC_W);
    logic [DIV_W:0] acc_reg;
    logic [DIV_W:0] sum;

    assign sum = acc_reg + STEP;

    // sixteenths accumulate so the fractional part spreads evenly
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            acc_reg <= '0;
            tick <= 1'b0;
        end else if (!enable || divider == '0) begin
            acc_reg <= '0;
            tick <= 1'b0;
        end else if (sum >= {1'b0, divider}) begin
            acc_reg <= sum - {1'b0, divider};
            tick <= 1'b1;
        end else begin
            acc_reg <= sum;
            tick <= 1'b0;
        end
    end
endmodule : uht_baud
`default_nettype wire

/* File: verilog/uht_core.sv */
// half-duplex capable asynchronous serial transceiver core
// assumes a single-cycle register port and a pad that resolves tx enables
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - half-duplex: rx ignored, open-drain tx looped back
// - frame length from word length and stop bits; parity takes a data bit
// - parity select zero even, one odd
// - stop bits 1, 0.5, 2, 1.5
// - low start, data lsb first, high stops
// - enabling transmitter sends one idle frame
// - data write clears empty, shifter takes word
// - frame end with empty buffer sets complete
// - break after current frame, then self-clears
// - receive lsb first, store sets not-empty
// - not-empty cleared by read, or by write zero with dma off
// - received break gives frame error
// - idle line after frame raises idle
// - oversampling select chooses 8x or 16x
// - overrun keeps data register, drops new word
// - status read then data read clears errors
// - noise flag rises with not-empty
// - missing stop sets frame error
// - 12.4 fractional baud divider
module uht_core
    import uht_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [DATA_W-1:0] bus_rdata,
    input wire logic rx_i,
    input wire logic tx_i,
    output logic tx_o,
    output logic tx_oe,
    output logic irq
);
    uht_ctrl1_s c1_reg;
    uht_ctrl2_s c2_reg;
    logic [DIV_W-1:0] baud_divider_reg;
    uht_tx_e tx_state_reg;
    uht_rx_e rx_state_reg;

    logic wr_c1, wr_c2, wr_baud, wr_sts, wr_data, rd_sts, rd_data;
    logic tick, tx_run, rx_run, rline, s_rx, s_tx;
    logic [5:0] os, mid, stop_len;
    logic [3:0] nbits;
    logic [2:0] halves;

    // register decode
    always_comb begin
        wr_c1 = 1'b0;
        wr_c2 = 1'b0;
        wr_baud = 1'b0;
        wr_sts = 1'b0;
        wr_data = 1'b0;
        if (bus_addr == OFS_CTRL1) begin
            wr_c1 = bus_wr;
        end else if (bus_addr == OFS_CTRL2) begin
            wr_c2 = bus_wr;
        end else if (bus_addr == OFS_BAUD) begin
            wr_baud = bus_wr;
        end else if (bus_addr == OFS_STS) begin
            wr_sts = bus_wr;
        end else if (bus_addr == OFS_DATA) begin
            wr_data = bus_wr;
        end
    end
    assign rd_sts = bus_rd && bus_addr == OFS_STS;
    assign rd_data = bus_rd && bus_addr == OFS_DATA;

    assign tx_run = c1_reg.peripheral_enable && c1_reg.transmit_enable;
    assign rx_run = c1_reg.peripheral_enable && c1_reg.receive_enable;
    assign os = c1_reg.oversampling_select ? OS_HALF : OS_FULL;
    assign mid = os >> 1;
    assign nbits = c1_reg.word_length_select ? BITS_9 : BITS_8;

    always_comb begin
        case (c2_reg.stop_bits_select)
            STOP_HALF: halves = HALVES_HALF;
            STOP_2: halves = HALVES_2;
            STOP_ONEHALF: halves = HALVES_ONEHALF;
            default: halves = HALVES_1;
        endcase
    end
    assign stop_len = 6'(halves * mid);

    uht_baud #(
        .DIV_W(DIV_W),
        .FRAC_W(FRAC_W)
    ) u_baud (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .enable(c1_reg.peripheral_enable),
        .divider(baud_divider_reg),
        .tick(tick)
    );

    uht_sync #(
        .W(2)
    ) u_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .din({tx_i, rx_i}),
        .dout({s_tx, s_rx})
    );

    // rx pin unused in half-duplex; the shared tx wire feeds the receiver
    assign rline = c2_reg.half_duplex_enable ? s_tx : s_rx;

    // transmitter
    logic [FRAME_W-1:0] tsh_reg;
    logic [5:0] tcnt_reg;
    logic [3:0] tbit_reg;
    logic [WORD_W-1:0] tdr_reg, tword;
    logic te_q_reg, pend_idle_reg, cur_brk_reg, tx_empty_reg, tc_reg;
    logic frame_done, tline;

    // parity bit replaces the top data bit when enabled
    always_comb begin
        tword = c1_reg.word_length_select ? tdr_reg : {1'b0, tdr_reg[7:0]};
        if (c1_reg.parity_enable && c1_reg.word_length_select) begin
            tword[8] = ^tdr_reg[7:0] ^ c1_reg.parity_select;
        end else if (c1_reg.parity_enable) begin
            tword[7] = ^tdr_reg[6:0] ^ c1_reg.parity_select;
        end
    end

    assign frame_done = tx_state_reg == TX_STOP && tick &&
        tcnt_reg == stop_len - 6'h01;
    assign tline = tx_state_reg == TX_BITS ? tsh_reg[0] : 1'b1;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_state_reg <= TX_IDLE;
            tsh_reg <= '1;
            tcnt_reg <= '0;
            tbit_reg <= '0;
            cur_brk_reg <= 1'b0;
        end else begin
            case (tx_state_reg)
                TX_IDLE: begin
                    tcnt_reg <= '0;
                    tbit_reg <= '0;
                    if (tx_run && pend_idle_reg) begin
                        tsh_reg <= '1;
                        cur_brk_reg <= 1'b0;
                        tx_state_reg <= TX_BITS;
                    end else if (tx_run && c1_reg.break_request) begin
                        tsh_reg <= '0;
                        cur_brk_reg <= 1'b1;
                        tx_state_reg <= TX_BITS;
                    end else if (tx_run && !tx_empty_reg) begin
                        tsh_reg <= {1'b1, tword, 1'b0};
                        cur_brk_reg <= 1'b0;
                        tx_state_reg <= TX_BITS;
                    end
                end
                TX_BITS: begin
                    if (tick && tcnt_reg == os - 6'h01) begin
                        tcnt_reg <= '0;
                        tsh_reg <= {1'b1, tsh_reg[FRAME_W-1:1]};
                        tbit_reg <= tbit_reg + 4'h1;
                        if (tbit_reg == nbits) begin
                            tx_state_reg <= TX_STOP;
                        end
                    end else if (tick) begin
                        tcnt_reg <= tcnt_reg + 6'h01;
                    end
                end
                TX_STOP: begin
                    if (frame_done) begin
                        tx_state_reg <= TX_IDLE;
                    end else if (tick) begin
                        tcnt_reg <= tcnt_reg + 6'h01;
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // transmit buffer and its flags; complete set wins over clear, data write wins over empty set
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            te_q_reg <= 1'b0;
            pend_idle_reg <= 1'b0;
            tdr_reg <= '0;
            tx_empty_reg <= 1'b1;
            tc_reg <= 1'b0;
        end else begin
            te_q_reg <= tx_run;
            if (tx_run && !te_q_reg) begin
                pend_idle_reg <= 1'b1;
            end else if (tx_state_reg == TX_IDLE && tx_run) begin
                pend_idle_reg <= 1'b0;
            end
            if (tx_state_reg == TX_IDLE && tx_run && !pend_idle_reg &&
                !c1_reg.break_request && !tx_empty_reg) begin
                tx_empty_reg <= 1'b1;
            end
            if (wr_sts && !bus_wdata[STS_TC]) begin
                tc_reg <= 1'b0;
            end
            if (wr_data) begin
                tdr_reg <= bus_wdata[WORD_W-1:0];
                tx_empty_reg <= 1'b0;
                tc_reg <= 1'b0;
            end
            if (frame_done && tx_empty_reg) begin
                tc_reg <= 1'b1;
            end
        end
    end

    // control registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            c1_reg <= '0;
            c2_reg <= '0;
            baud_divider_reg <= '0;
        end else begin
            if (wr_c1) begin
                c1_reg <= uht_ctrl1_s'(bus_wdata[CTRL1_W-1:0]);
            end else if (frame_done && cur_brk_reg) begin
                c1_reg.break_request <= 1'b0;
            end
            if (wr_c2) begin
                c2_reg <= uht_ctrl2_s'(bus_wdata[CTRL2_W-1:0]);
            end
            if (wr_baud) begin
                baud_divider_reg <= bus_wdata[DIV_W-1:0];
            end
        end
    end

    // receiver: three samples around mid-bit, majority wins
    logic [5:0] rcnt_reg;
    logic [3:0] rbit_reg;
    logic [WORD_W-1:0] rsh_reg, rword, rdr_reg;
    logic [1:0] smp_reg;
    logic [7:0] icnt_reg, idle_len;
    logic rnoise_reg, armed_reg, idle_arm_reg;
    logic eval, maj, nz, rx_done, idle_hit;

    assign eval = tick && rcnt_reg == mid + 6'h01;
    assign maj = (smp_reg[0] & smp_reg[1]) | (smp_reg[0] & rline) |
        (smp_reg[1] & rline);
    assign nz = !(smp_reg[0] == smp_reg[1] && smp_reg[1] == rline);
    assign rx_done = rx_state_reg == RX_STOP && eval;
    assign rword = c1_reg.word_length_select ? rsh_reg :
        {1'b0, rsh_reg[WORD_W-1:1]};
    assign idle_len = c1_reg.oversampling_select ?
        {1'b0, nbits + IDLE_EXTRA, 3'h0} : {nbits + IDLE_EXTRA, 4'h0};
    assign idle_hit = rx_state_reg == RX_IDLE && idle_arm_reg && tick &&
        rline && icnt_reg == idle_len - 8'h01;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_state_reg <= RX_IDLE;
            rcnt_reg <= '0;
            rbit_reg <= '0;
            rsh_reg <= '0;
            smp_reg <= '0;
            rnoise_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else if (!rx_run) begin
            rx_state_reg <= RX_IDLE;
            armed_reg <= 1'b0;
        end else begin
            case (rx_state_reg)
                RX_IDLE: begin
                    rcnt_reg <= '0;
                    rbit_reg <= '0;
                    rnoise_reg <= 1'b0;
                    // a break must go high again before a new start counts
                    if (rline) begin
                        armed_reg <= 1'b1;
                    end else if (armed_reg) begin
                        armed_reg <= 1'b0;
                        rx_state_reg <= RX_BITS;
                    end
                end
                RX_BITS, RX_STOP: begin
                    if (tick) begin
                        rcnt_reg <= rcnt_reg == os - 6'h01 ? 6'h00 :
                            rcnt_reg + 6'h01;
                    end
                    if (tick && rcnt_reg == mid - 6'h01) begin
                        smp_reg[0] <= rline;
                    end
                    if (tick && rcnt_reg == mid) begin
                        smp_reg[1] <= rline;
                    end
                    if (rx_done) begin
                        rx_state_reg <= RX_IDLE;
                    end else if (eval && rbit_reg == '0 && maj) begin
                        rx_state_reg <= RX_IDLE;
                    end else if (eval) begin
                        rnoise_reg <= rnoise_reg | nz;
                        rbit_reg <= rbit_reg + 4'h1;
                        if (rbit_reg != '0) begin
                            rsh_reg <= {maj, rsh_reg[WORD_W-1:1]};
                        end
                        if (rbit_reg == nbits) begin
                            rx_state_reg <= RX_STOP;
                        end
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // line-high counter for idle frame detection
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            icnt_reg <= '0;
            idle_arm_reg <= 1'b0;
        end else begin
            if (rx_state_reg != RX_IDLE || !rline || idle_hit) begin
                icnt_reg <= '0;
            end else if (tick) begin
                icnt_reg <= icnt_reg + 8'h01;
            end
            if (rx_done) begin
                idle_arm_reg <= 1'b1;
            end else if (idle_hit || !rx_run) begin
                idle_arm_reg <= 1'b0;
            end
        end
    end

    // receive flags; every hardware set is placed after its clears
    logic rxne_reg, ovr_reg, ne_reg, fe_reg, idle_reg, sts_seen_reg;
    logic err_clr;

    assign err_clr = rd_data && sts_seen_reg;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdr_reg <= '0;
            rxne_reg <= 1'b0;
            ovr_reg <= 1'b0;
            ne_reg <= 1'b0;
            fe_reg <= 1'b0;
            idle_reg <= 1'b0;
            sts_seen_reg <= 1'b0;
        end else begin
            if (rd_sts) begin
                sts_seen_reg <= 1'b1;
            end else if (bus_rd || bus_wr) begin
                sts_seen_reg <= 1'b0;
            end
            if (rd_data) begin
                rxne_reg <= 1'b0;
            end
            if (wr_sts && !bus_wdata[STS_RXNE] && !c2_reg.dma_enable) begin
                rxne_reg <= 1'b0;
            end
            if (wr_sts && !bus_wdata[STS_IDLE]) begin
                idle_reg <= 1'b0;
            end
            if (err_clr) begin
                ovr_reg <= 1'b0;
                ne_reg <= 1'b0;
                fe_reg <= 1'b0;
            end
            if (idle_hit) begin
                idle_reg <= 1'b1;
            end
            if (rx_done && rxne_reg) begin
                ovr_reg <= 1'b1;
            end else if (rx_done) begin
                rdr_reg <= rword;
                rxne_reg <= 1'b1;
                ne_reg <= rnoise_reg | nz;
                fe_reg <= !maj;
            end
        end
    end

    // read data, pins and interrupt all leave from flip-flops
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bus_rdata <= '0;
            tx_o <= 1'b1;
            tx_oe <= 1'b0;
            irq <= 1'b0;
        end else begin
            bus_rdata <= '0;
            if (bus_rd && bus_addr == OFS_CTRL1) begin
                bus_rdata <= DATA_W'(c1_reg);
            end else if (bus_rd && bus_addr == OFS_CTRL2) begin
                bus_rdata <= DATA_W'(c2_reg);
            end else if (bus_rd && bus_addr == OFS_BAUD) begin
                bus_rdata <= DATA_W'(baud_divider_reg);
            end else if (rd_sts) begin
                bus_rdata <= DATA_W'({fe_reg, ne_reg, ovr_reg, idle_reg,
                    rxne_reg, tc_reg, tx_empty_reg});
            end else if (rd_data) begin
                bus_rdata <= DATA_W'(rdr_reg);
            end
            if (!tx_run) begin
                tx_o <= 1'b1;
                tx_oe <= 1'b0;
            end else if (c2_reg.half_duplex_enable) begin
                tx_o <= 1'b0;
                tx_oe <= !tline;
            end else begin
                tx_o <= tline;
                tx_oe <= 1'b1;
            end
            irq <= (tx_empty_reg && c1_reg.tx_empty_irq_enable) ||
                (tc_reg && c1_reg.tx_complete_irq_enable) ||
                ((rxne_reg || ovr_reg) &&
                 c1_reg.rx_not_empty_irq_enable) ||
                (idle_reg && c1_reg.idle_irq_enable) ||
                (fe_reg && c2_reg.dma_enable &&
                 c1_reg.error_irq_enable);
        end
    end

    a_open_drain: assert property (@(posedge clk_sys) disable iff (!arst_n)
        c2_reg.half_duplex_enable && tx_run |=> !tx_o)
        else $error("half-duplex tx drove high");
    a_parity_sense: assert property (@(posedge clk_sys) disable iff (!arst_n)
        c1_reg.parity_enable && c1_reg.word_length_select |->
        (^tword) == c1_reg.parity_select)
        else $error("parity bit wrong");
    a_start_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
        tx_state_reg == TX_BITS && tbit_reg == '0 && !pend_idle_reg &&
        !te_q_reg == 1'b0 && tsh_reg != '1 |-> tline == 1'b0)
        else $error("start bit not low");
    a_empty_on_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_data && tx_run && tx_state_reg == TX_IDLE |=> !tx_empty_reg ##1
        (tx_empty_reg || tx_state_reg != TX_IDLE || !tx_run))
        else $error("empty flag wrong after write");
    a_tc_at_end: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_done && tx_empty_reg |=> tc_reg)
        else $error("complete flag not set");
    a_break_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
        frame_done && cur_brk_reg && !wr_c1 |=> !c1_reg.break_request)
        else $error("break request not cleared");
    a_rxne_store: assert property (@(posedge clk_sys) disable iff (!arst_n)
        rx_done && !rxne_reg |=> rxne_reg && rdr_reg == $past(rword))
        else $error("word not stored");
    a_overrun_keep: assert property (@(posedge clk_sys) disable iff (!arst_n)
        rx_done && rxne_reg && !rd_data |=> ovr_reg && $stable(rdr_reg))
        else $error("overrun handling wrong");
    a_err_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
        rd_sts ##1 (rd_data && !rx_done) |=> !ovr_reg && !fe_reg)
        else $error("error flags not cleared");
    a_err_clear_gap: assert property (@(posedge clk_sys)
        disable iff (!arst_n) rd_sts ##1 (!bus_rd && !bus_wr) ##1
        (rd_data && !rx_done) |=> !ovr_reg && !fe_reg && !ne_reg)
        else $error("error flags kept after idle gap");
    a_frame_error: assert property (@(posedge clk_sys) disable iff (!arst_n)
        rx_done && !rxne_reg && !maj |=> fe_reg)
        else $error("missing stop not flagged");
endmodule : uht_core
`default_nettype wire

/* File: testbench/uht_remote.sv */
// remote serial device: sends frames on rx, decodes frames seen on tx
// assumes idle-high line and a bit of P clk_sys cycles
`timescale 1ns/10ps
`default_nettype none
module uht_remote #(
    parameter int P = 64
) (
    input wire logic clk_sys,
    input wire logic line_i,
    input wire logic [3:0] nbits,
    output logic rx_o,
    output logic [8:0] got,
    output int n_got
);
    initial begin
        rx_o = 1'b1;
        got = '0;
        n_got = 0;
    end
    // sample at mid-bit; a frame counts only with a high stop
    always begin : dec
        @(negedge line_i);
        repeat (P / 2) @(posedge clk_sys);
        if (!line_i) begin
            got = '0;
            for (int i = 0; i < nbits; i++) begin
                repeat (P) @(posedge clk_sys);
                got[i] = line_i;
            end
            repeat (P) @(posedge clk_sys);
            if (line_i) n_got++;
        end
    end
    task send(input logic [8:0] w, input logic stop);
        @(posedge clk_sys) rx_o <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            repeat (P) @(posedge clk_sys);
            rx_o <= w[i];
        end
        repeat (P) @(posedge clk_sys);
        rx_o <= stop;
        repeat (P) @(posedge clk_sys);
        rx_o <= 1'b1;
        repeat (2 * P) @(posedge clk_sys);
    endtask : send
endmodule : uht_remote
`default_nettype wire

/* File: testbench/uht_core_tb.sv */
// self-checking bench of the serial core against a remote device
// assumes a pulled-up tx wire and a divider of 64 cycles a bit
`timescale 1ns/10ps
`default_nettype none
module uht_core_tb;
    import uht_pkg::*;
    logic clk_sys = 0, arst_n = 0, bus_wr = 0, bus_rd = 0;
    logic [7:0] bus_addr = '0;
    logic [31:0] bus_wdata = '0, bus_rdata, v;
    logic tx_o, tx_oe, irq, rx_line, tx_line, hd = 1'b0;
    logic [3:0] nb = 4'h8;
    logic [8:0] got;
    int n_got, n_mismatch = 0, checks_done = 0;
    // in half-duplex the remote pulls the shared wire; rx pin held low
    assign tx_line = (tx_oe ? tx_o : 1'b1) & (rx_line | !hd);
    uht_core u_uht_core(.clk_sys(clk_sys), .arst_n(arst_n),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rx_i(rx_line & !hd),
        .tx_i(tx_line), .tx_o(tx_o), .tx_oe(tx_oe), .irq(irq));
    uht_remote #(.P(64)) u_uht_remote(.clk_sys(clk_sys), .line_i(tx_line),
        .nbits(nb), .rx_o(rx_line), .got(got), .n_got(n_got));
    initial forever #10 clk_sys = ~clk_sys;
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys) bus_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys) bus_rd <= 1'b0;
        #1 v = bus_rdata;
    endtask : rd
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk
    // bounded poll of one status bit
    task wait_sts(input int b);
        v = '0;
        for (int i = 0; i < 2000 && v[b] !== 1'b1; i++) rd(OFS_STS);
        chk(v[b], 1'b1);
    endtask : wait_sts
    task wrap_up;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up
    task t_tx;
        rd(OFS_STS);
        chk(v, 32'h0000_0001);
        wr(OFS_BAUD, 32'h0000_0040);
        wr(OFS_CTRL1, 32'h0000_0207);
        wr(OFS_DATA, 32'h0000_00A5);
        repeat (900) @(posedge clk_sys);
        chk(n_got, 0);
        wait_sts(STS_TC);
        chk(v, 32'h0000_0003);
        chk(irq, 1'b1);
        chk({23'h0, got}, 32'h0000_00A5);
        chk(n_got, 1);
    endtask : t_tx
    // 7 data bits plus parity, even then odd
    task t_par;
        for (int p = 0; p < 2; p++) begin
            wr(OFS_CTRL1, 32'h0000_0017 | (p << 5));
            wr(OFS_DATA, 32'h0000_0053);
            wait_sts(STS_TC);
            chk({23'h0, got}, {24'h0, 1'(p), 7'h53});
        end
    endtask : t_par
    task t_rx;
        wr(OFS_CTRL1, 32'h0000_0007);
        u_uht_remote.send(9'h03C, 1'b1);
        wait_sts(STS_RXNE);
        rd(OFS_DATA);
        chk(v, 32'h0000_003C);
        rd(OFS_STS);
        chk(v[STS_RXNE], 1'b0);
        u_uht_remote.send(9'h011, 1'b1);
        u_uht_remote.send(9'h022, 1'b1);
        rd(OFS_STS);
        chk(v & 32'h14, 32'h14);
        rd(OFS_DATA);
        chk(v, 32'h0000_0011);
        rd(OFS_STS);
        chk(v[STS_OVR], 1'b0);
        u_uht_remote.send(9'h000, 1'b0);
        wait_sts(STS_RXNE);
        chk(v[STS_FE], 1'b1);
    endtask : t_rx
    // break frame, then hardware drops the request
    task t_brk;
        wr(OFS_STS, 32'h0000_0000);
        wr(OFS_CTRL1, 32'h0000_0083);
        wait_sts(STS_TC);
        rd(OFS_CTRL1);
        chk(v, 32'h0000_0003);
        chk(got, 32'h0000_0000);
    endtask : t_brk
    // 8x with doubled divider keeps 64 cycles a bit; 9 data bits
    task t_os;
        wr(OFS_BAUD, 32'h0000_0080);
        wr(OFS_CTRL1, 32'h0000_004B);
        nb <= 4'h9;
        wr(OFS_DATA, 32'h0000_0196);
        wait_sts(STS_TC);
        chk(got, 32'h0000_0196);
        nb <= 4'h8;
        wr(OFS_BAUD, 32'h0000_0040);
    endtask : t_os
    task t_hd;
        wr(OFS_STS, 32'h0000_0000);
        wr(OFS_CTRL2, 32'h0000_0004);
        hd <= 1'b1;
        wr(OFS_CTRL1, 32'h0000_0003);
        wr(OFS_DATA, 32'h0000_005A);
        wait_sts(STS_TC);
        chk(got, 32'h0000_005A);
        wr(OFS_CTRL1, 32'h0000_0007);
        u_uht_remote.send(9'h0C3, 1'b1);
        wait_sts(STS_RXNE);
        rd(OFS_DATA);
        chk(v, 32'h0000_00C3);
        wait_sts(STS_IDLE);
    endtask : t_hd
    initial begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_tx;
        t_par;
        t_rx;
        t_brk;
        t_os;
        t_hd;
        wrap_up;
    end
    initial begin
        #1ms;
        n_mismatch++;
        wrap_up;
    end
endmodule : uht_core_tb
`default_nettype wire
